// ===== ahp_pkg.sv
// Purpose: shared constants, types and helpers for both port ends
// Assumes: both ends run clk at 50 MHz
// Notes: every link pin is resynchronised by the end that receives it
`default_nettype none
package ahp_pkg;
  localparam int CLK_NS = 20;
  localparam int DW = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 11;
  localparam int RESET_US = 25;
  localparam int PIO_SETUP_NS = 60;
  localparam int PIO_PULSE_NS = 240;
  localparam int PIO_HOLD_NS = 60;
  localparam int STRB_SETUP_NS = 40;
  localparam int STRB_HOLD_NS = 40;
  localparam int DACK_NS = 80;
  localparam int TERM_NS = 160;
  // least times, so every count rounds up
  localparam int RESET_CYC = (RESET_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PIO_SETUP_CYC = (PIO_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIO_PULSE_CYC = (PIO_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIO_HOLD_CYC = (PIO_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRB_SETUP_CYC = (STRB_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STRB_HOLD_CYC = (STRB_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DACK_CYC = (DACK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TERM_CYC = (TERM_NS + CLK_NS - 1) / CLK_NS;
  // margin for words already in flight when ready drops
  localparam int RX_READY_MAX = FIFO_DEPTH - 3;

  typedef logic [CNT_W-1:0] ahp_cnt_t;

  typedef struct packed {
    logic rst_n;
    logic cs0_n;
    logic cs1_n;
    logic [2:0] da;
    logic diow_n;
    logic dior_n;
    logic dmack_n;
    logic [DW-1:0] dd;
  } ahp_dev_in_s;

  typedef struct packed {
    logic iordy;
    logic dmarq;
    logic intrq;
    logic [DW-1:0] dd;
  } ahp_host_in_s;

  localparam ahp_dev_in_s DEV_IN_IDLE = '1;
  localparam ahp_host_in_s HOST_IN_IDLE = '{iordy: 1'b1, dmarq: 1'b0,
                                            intrq: 1'b0, dd: 16'hFFFF};

  function automatic logic cnt_done(input ahp_cnt_t c, input int n);
    return c >= ahp_cnt_t'(n - 1);
  endfunction
endpackage
`default_nettype wire

// ===== ahp_if.sv
// Purpose: the 40-pin parallel port between host and device
// Assumes: no end drives the data bus while the other does
// Notes: an undriven data bus reads high, as its pull-ups make it
`timescale 1ns/10ps
`default_nettype none
interface ahp_if;
  logic rst_line_n;
  logic cs0_n;
  logic cs1_n;
  logic [2:0] da;
  logic diow_n;
  logic dior_n;
  logic dmack_n;
  logic h_dd_oe;
  logic [ahp_pkg::DW-1:0] h_dd_out;
  logic iordy;
  logic dmarq;
  logic intrq;
  logic d_dd_oe;
  logic [ahp_pkg::DW-1:0] d_dd_out;
  logic [ahp_pkg::DW-1:0] dd;

  assign dd = h_dd_oe ? h_dd_out : (d_dd_oe ? d_dd_out : 16'hFFFF);

  modport host (output rst_line_n, cs0_n, cs1_n, da, diow_n, dior_n,
                dmack_n, h_dd_oe, h_dd_out,
                input iordy, dmarq, intrq, dd);
  modport dev (input rst_line_n, cs0_n, cs1_n, da, diow_n, dior_n,
               dmack_n, dd,
               output iordy, dmarq, intrq, d_dd_oe, d_dd_out);
endinterface
`default_nettype wire

// ===== ahp_device.sv
// Purpose: device end of the port: register strobes and Ultra DMA bursts
// Assumes: all link inputs are asynchronous to clk
// Notes: tx words go out on dstrobe, rx words arrive on hstrobe edges
`timescale 1ns/10ps
`default_nettype none
module ahp_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D+1)-1:0] level
);
  localparam int AW = $clog2(D);
  localparam int LW = $clog2(D + 1);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [LW-1:0] cnt_reg;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = cnt_reg != LW'(D);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign level = cnt_reg;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= bump(wr_reg);
      end
      if (pop) begin
        rd_reg <= bump(rd_reg);
      end
      cnt_reg <= LW'(cnt_reg + LW'(push) - LW'(pop));
    end
  end
endmodule

module ahp_device (
  input wire logic clk,
  input wire logic reset_n,
  ahp_if.dev link,
  output logic pio_wr,
  output logic pio_rd,
  output logic pio_ctrl,
  output logic [2:0] pio_da,
  output logic [ahp_pkg::DW-1:0] pio_wdata,
  input wire logic [ahp_pkg::DW-1:0] pio_rdata,
  input wire logic intrq_req,
  input wire logic dma_enable,
  input wire logic dma_in_mode,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [ahp_pkg::DW-1:0] tx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [ahp_pkg::DW-1:0] rx_data,
  output logic burst_active,
  output logic link_reset
);
  typedef enum logic [1:0] {D_IDLE, D_IN, D_OUT} ahp_dstate_e;
  localparam int LW = $clog2(ahp_pkg::FIFO_DEPTH + 1);

  ahp_pkg::ahp_dev_in_s pins;
  ahp_pkg::ahp_dev_in_s q_next;
  ahp_pkg::ahp_dev_in_s s1_reg;
  ahp_pkg::ahp_dev_in_s s2_reg;
  ahp_pkg::ahp_dev_in_s s3_reg;
  ahp_pkg::ahp_dev_in_s q_reg;
  ahp_pkg::ahp_dev_in_s p_reg;
  ahp_dstate_e state_reg;
  ahp_pkg::ahp_cnt_t cnt_reg;
  logic word_ld_reg;
  logic strobe_reg;
  logic dd_oe_reg;
  logic [ahp_pkg::DW-1:0] dd_out_reg;
  logic dmarq_reg;
  logic iordy_reg;
  logic intrq_reg;
  logic txf_valid;
  logic [ahp_pkg::DW-1:0] txf_data;
  logic rxf_room;
  logic [LW-1:0] rxf_level;

  assign pins = {link.rst_line_n, link.cs0_n, link.cs1_n, link.da,
                 link.diow_n, link.dior_n, link.dmack_n, link.dd};
  // a bit moves only once the second and third stages agree
  assign q_next = (s2_reg & s3_reg) | (q_reg & (s2_reg ^ s3_reg));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= ahp_pkg::DEV_IN_IDLE;
      s2_reg <= ahp_pkg::DEV_IN_IDLE;
      s3_reg <= ahp_pkg::DEV_IN_IDLE;
      q_reg <= ahp_pkg::DEV_IN_IDLE;
      p_reg <= ahp_pkg::DEV_IN_IDLE;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
      p_reg <= q_reg;
    end
  end

  // strobe pins mean register access only while dmack is negated
  wire dmack = !q_reg.dmack_n;
  wire stop = q_reg.diow_n; // R06 R15
  wire pio_ok = q_reg.dmack_n & q_reg.rst_n; // R15
  wire cs_any = !q_reg.cs0_n | !q_reg.cs1_n;
  wire wr_fall = p_reg.diow_n & !q_reg.diow_n;
  wire rd_fall = p_reg.dior_n & !q_reg.dior_n;
  wire rd_rise = !p_reg.dior_n & q_reg.dior_n;
  wire rd_toggle = p_reg.dior_n ^ q_reg.dior_n;
  wire rx_ok = rxf_level <= LW'(ahp_pkg::RX_READY_MAX);
  wire idle = state_reg == D_IDLE;
  wire go = idle & dmarq_reg & dmack & !stop;
  wire end_burst = !idle & (stop | !dmack | !q_reg.rst_n); // R06
  wire in_load = (state_reg == D_IN) & !word_ld_reg & txf_valid &
                 ahp_pkg::cnt_done(cnt_reg, ahp_pkg::STRB_HOLD_CYC);
  // host readiness is the read strobe pin inside a data-in burst
  wire in_fire = (state_reg == D_IN) & word_ld_reg & !end_burst &
                 !q_reg.dior_n & // R15
                 ahp_pkg::cnt_done(cnt_reg, ahp_pkg::STRB_SETUP_CYC);
  wire out_take = (state_reg == D_OUT) & rd_toggle & !end_burst; // R14
  wire want_in = txf_valid | word_ld_reg;
  wire want_out = (state_reg == D_OUT) | (rx_ok & rxf_room);
  wire want = dma_enable & q_reg.rst_n &
              (dma_in_mode ? want_in : want_out);
  // dstrobe leaves with the toggle itself, so the word keeps its full hold
  wire iordy_next = (state_reg == D_IN) ? (strobe_reg ^ in_fire) :
                    ((state_reg == D_OUT) ? !rx_ok : 1'b1);

  assign pio_wr = pio_ok & wr_fall & cs_any;
  assign pio_rd = pio_ok & rd_fall & cs_any;
  assign pio_ctrl = !q_reg.cs1_n;
  assign pio_da = q_reg.da;
  assign pio_wdata = q_reg.dd;
  assign burst_active = !idle;
  assign link_reset = !q_reg.rst_n;
  assign link.d_dd_oe = dd_oe_reg;
  assign link.d_dd_out = dd_out_reg;
  assign link.dmarq = dmarq_reg;
  assign link.iordy = iordy_reg;
  assign link.intrq = intrq_reg;

  ahp_fifo #(.W(ahp_pkg::DW), .D(ahp_pkg::FIFO_DEPTH)) u_tx (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(txf_valid),
    .out_ready(in_fire),
    .out_data(txf_data),
    .level()
  );

  // words are pushed only while u_rx has room; ddmardy keeps the level in range
  ahp_fifo #(.W(ahp_pkg::DW), .D(ahp_pkg::FIFO_DEPTH)) u_rx (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(out_take),
    .in_ready(rxf_room),
    .in_data(q_reg.dd),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data),
    .level(rxf_level)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= D_IDLE;
    end else if (end_burst) begin
      state_reg <= D_IDLE; // R06
    end else if (go) begin
      state_reg <= dma_in_mode ? D_IN : D_OUT;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
    end else if (go | in_load | in_fire) begin
      cnt_reg <= '0;
    end else if (cnt_reg != '1) begin
      cnt_reg <= ahp_pkg::ahp_cnt_t'(cnt_reg + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_ld_reg <= 1'b0;
      strobe_reg <= 1'b1;
    end else begin
      if (end_burst | in_fire) begin
        word_ld_reg <= 1'b0;
      end else if (in_load) begin
        word_ld_reg <= 1'b1;
      end
      if (go) begin
        strobe_reg <= 1'b1;
      end else if (in_fire) begin
        strobe_reg <= !strobe_reg; // R08
      end
    end
  end

  // pause on either side simply holds the strobe level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dd_out_reg <= 16'hFFFF;
      dd_oe_reg <= 1'b0;
    end else begin
      if (in_load) begin
        dd_out_reg <= txf_data;
      end else if (pio_rd) begin
        dd_out_reg <= pio_rdata;
      end
      if (pio_rd | (go & dma_in_mode)) begin
        dd_oe_reg <= 1'b1; // R02
      end else if (end_burst | (pio_ok & rd_rise) | !q_reg.rst_n) begin
        dd_oe_reg <= 1'b0; // R02
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dmarq_reg <= 1'b0;
      iordy_reg <= 1'b1;
      intrq_reg <= 1'b0;
    end else begin
      dmarq_reg <= want;
      iordy_reg <= iordy_next; // R07 R08 R15
      intrq_reg <= intrq_req & q_reg.rst_n;
    end
  end
endmodule
`default_nettype wire

// ===== ahp_host.sv
// Purpose: host end of the port: reset, register cycles, Ultra DMA bursts
// Assumes: all link inputs are asynchronous to clk
// Notes: the host alone ends a burst, by STOP, also when dmarq drops
`timescale 1ns/10ps
`default_nettype none
// Function
// R01: host holds reset low 25 us at start
// R02: one 16-bit bus, driven by direction
// R03: host pulses write strobe for register writes
// R04: write strobe negated before any burst starts
// R05: STOP negated until burst data moves
// R06: asserted STOP ends the burst
// R07: device drives ddmardy in data-out bursts
// R08: device drives dstrobe in data-in bursts
// R09: host drives hstrobe in data-out bursts
// R10: host drives hdmardy in data-in bursts
// R11: only the host drives STOP
// R12: three address lines plus two chip selects
// R13: CS0 command block, CS1 control block
// R14: both hstrobe edges latch one word
// R15: shared pins read by transfer phase
module ahp_host (
  input wire logic clk,
  input wire logic reset_n,
  ahp_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_ctrl,
  input wire logic [2:0] cmd_da,
  input wire logic [ahp_pkg::DW-1:0] cmd_wdata,
  output logic rsp_valid,
  output logic [ahp_pkg::DW-1:0] rsp_rdata,
  input wire logic dma_in_mode,
  input wire logic stop_req,
  input wire logic in_pause,
  output logic in_valid,
  output logic [ahp_pkg::DW-1:0] in_data,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [ahp_pkg::DW-1:0] out_data,
  output logic intrq
);
  typedef enum logic [3:0] {
    H_RST, H_IDLE, H_SETUP, H_PULSE, H_HOLD, H_DACK, H_IN, H_OUT, H_TERM
  } ahp_hstate_e;

  ahp_pkg::ahp_host_in_s pins;
  ahp_pkg::ahp_host_in_s q_next;
  ahp_pkg::ahp_host_in_s s1_reg;
  ahp_pkg::ahp_host_in_s s2_reg;
  ahp_pkg::ahp_host_in_s s3_reg;
  ahp_pkg::ahp_host_in_s q_reg;
  ahp_pkg::ahp_host_in_s p_reg;
  ahp_hstate_e state_reg;
  ahp_hstate_e state_next;
  ahp_pkg::ahp_cnt_t cnt_reg;
  logic rst_line_reg;
  logic cs0_n_reg;
  logic cs1_n_reg;
  logic [2:0] da_reg;
  logic diow_n_reg;
  logic dior_n_reg;
  logic dmack_n_reg;
  logic dd_oe_reg;
  logic [ahp_pkg::DW-1:0] dd_out_reg;
  logic wr_reg;
  logic word_ld_reg;
  logic rsp_valid_reg;
  logic [ahp_pkg::DW-1:0] rsp_rdata_reg;
  logic in_valid_reg;
  logic [ahp_pkg::DW-1:0] in_data_reg;

  assign pins = {link.iordy, link.dmarq, link.intrq, link.dd};
  assign q_next = (s2_reg & s3_reg) | (q_reg & (s2_reg ^ s3_reg));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= ahp_pkg::HOST_IN_IDLE;
      s2_reg <= ahp_pkg::HOST_IN_IDLE;
      s3_reg <= ahp_pkg::HOST_IN_IDLE;
      q_reg <= ahp_pkg::HOST_IN_IDLE;
      p_reg <= ahp_pkg::HOST_IN_IDLE;
    end else begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
      p_reg <= q_reg;
    end
  end

  wire quit = stop_req | !q_reg.dmarq;
  wire take_cmd = (state_reg == H_IDLE) & cmd_valid;
  // iordy carries dstrobe in data-in and ddmardy in data-out
  wire dstrobe_edge = (state_reg == H_IN) &
                      (p_reg.iordy ^ q_reg.iordy); // R15
  wire ddmardy = !q_reg.iordy; // R15
  wire out_load = (state_reg == H_OUT) & !word_ld_reg & out_valid & !quit &
                  ahp_pkg::cnt_done(cnt_reg, ahp_pkg::STRB_HOLD_CYC);
  wire out_fire = (state_reg == H_OUT) & word_ld_reg & ddmardy &
                  ahp_pkg::cnt_done(cnt_reg, ahp_pkg::STRB_SETUP_CYC);
  wire moved = state_next != state_reg;
  wire enter_burst = (state_reg == H_DACK) & moved;
  wire enter_term = (state_next == H_TERM) & moved;
  wire end_pulse = (state_reg == H_PULSE) & moved;
  // a read leaves the device driving until it sees dior_n rise, so a
  // write that follows takes the bus only just before its strobe
  wire wr_drive = (state_reg == H_SETUP) & wr_reg &
                  ahp_pkg::cnt_done(cnt_reg, ahp_pkg::PIO_SETUP_CYC - 1);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      H_RST: begin
        if (ahp_pkg::cnt_done(cnt_reg, ahp_pkg::RESET_CYC)) begin
          state_next = H_IDLE;
        end
      end
      H_IDLE: begin
        if (cmd_valid) begin
          state_next = H_SETUP;
        end else if (q_reg.dmarq) begin
          state_next = H_DACK;
        end
      end
      H_SETUP: begin
        if (ahp_pkg::cnt_done(cnt_reg, ahp_pkg::PIO_SETUP_CYC)) begin
          state_next = H_PULSE;
        end
      end
      H_PULSE: begin
        if (ahp_pkg::cnt_done(cnt_reg, ahp_pkg::PIO_PULSE_CYC)) begin
          state_next = H_HOLD;
        end
      end
      H_HOLD: begin
        if (ahp_pkg::cnt_done(cnt_reg, ahp_pkg::PIO_HOLD_CYC)) begin
          state_next = H_IDLE;
        end
      end
      H_DACK: begin
        if (ahp_pkg::cnt_done(cnt_reg, ahp_pkg::DACK_CYC)) begin
          state_next = dma_in_mode ? H_IN : H_OUT;
        end
      end
      H_IN: begin
        if (quit) begin
          state_next = H_TERM;
        end
      end
      H_OUT: begin
        // a word already on the bus is strobed before the burst ends
        if (quit & !word_ld_reg) begin
          state_next = H_TERM;
        end
      end
      H_TERM: begin
        if (ahp_pkg::cnt_done(cnt_reg, ahp_pkg::TERM_CYC)) begin
          state_next = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= H_RST;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (moved | out_load | out_fire) begin
        cnt_reg <= '0;
      end else if (cnt_reg != '1) begin
        cnt_reg <= ahp_pkg::ahp_cnt_t'(cnt_reg + 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_line_reg <= 1'b0;
    end else begin
      rst_line_reg <= state_next != H_RST; // R01
    end
  end

  // address and selects stay put across the whole strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs0_n_reg <= 1'b1;
      cs1_n_reg <= 1'b1;
      da_reg <= '0;
      wr_reg <= 1'b0;
    end else if (take_cmd) begin
      cs0_n_reg <= cmd_ctrl; // R12 R13
      cs1_n_reg <= !cmd_ctrl; // R13
      da_reg <= cmd_da; // R12
      wr_reg <= cmd_write;
    end else if ((state_reg == H_HOLD) & moved) begin
      cs0_n_reg <= 1'b1;
      cs1_n_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dd_out_reg <= 16'hFFFF;
      dd_oe_reg <= 1'b0;
    end else begin
      if (take_cmd) begin
        dd_out_reg <= cmd_wdata;
      end else if (out_load) begin
        dd_out_reg <= out_data;
      end
      if (wr_drive) begin
        dd_oe_reg <= 1'b1; // R02
      end else if (enter_burst) begin
        dd_oe_reg <= !dma_in_mode; // R02
      end else if (enter_term | ((state_reg == H_HOLD) & moved)) begin
        dd_oe_reg <= 1'b0; // R02
      end
    end
  end

  // the write pin is STOP once dmack is low; only this end drives it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      diow_n_reg <= 1'b1;
    end else if ((state_next == H_PULSE) & moved & wr_reg) begin
      diow_n_reg <= 1'b0; // R03
    end else if (end_pulse | enter_term) begin
      diow_n_reg <= 1'b1; // R06 R11
    end else if (enter_burst) begin
      diow_n_reg <= 1'b0; // R05 R11
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dior_n_reg <= 1'b1;
    end else if ((state_next == H_PULSE) & moved & !wr_reg) begin
      dior_n_reg <= 1'b0;
    end else if (end_pulse | enter_term) begin
      dior_n_reg <= 1'b1;
    end else if (state_next == H_IN) begin
      dior_n_reg <= in_pause; // R10 R15
    end else if (out_fire) begin
      dior_n_reg <= !dior_n_reg; // R09 R14
    end
  end

  // dmack falls only with both strobes already high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dmack_n_reg <= 1'b1;
    end else if ((state_next == H_DACK) & moved) begin
      dmack_n_reg <= 1'b0; // R04
    end else if ((state_reg == H_TERM) & moved) begin
      dmack_n_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_ld_reg <= 1'b0;
    end else if (out_fire | enter_term) begin
      word_ld_reg <= 1'b0;
    end else if (out_load) begin
      word_ld_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= '0;
      in_valid_reg <= 1'b0;
      in_data_reg <= '0;
    end else begin
      rsp_valid_reg <= end_pulse & !wr_reg;
      if (end_pulse & !wr_reg) begin
        rsp_rdata_reg <= q_reg.dd;
      end
      in_valid_reg <= dstrobe_edge; // R08
      if (dstrobe_edge) begin
        in_data_reg <= q_reg.dd;
      end
    end
  end

  assign cmd_ready = state_reg == H_IDLE;
  assign out_ready = out_fire;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rsp_rdata_reg;
  assign in_valid = in_valid_reg;
  assign in_data = in_data_reg;
  assign intrq = q_reg.intrq;
  assign link.rst_line_n = rst_line_reg;
  assign link.cs0_n = cs0_n_reg;
  assign link.cs1_n = cs1_n_reg;
  assign link.da = da_reg;
  assign link.diow_n = diow_n_reg;
  assign link.dior_n = dior_n_reg;
  assign link.dmack_n = dmack_n_reg;
  assign link.h_dd_oe = dd_oe_reg;
  assign link.h_dd_out = dd_out_reg;
endmodule
`default_nettype wire

// ===== ahp_monitor.sv
// Purpose: watch the cable between the two port ends
// Assumes: one clock and one reset serve both ends
// Notes: reads only the shared interface signals
`timescale 1ns/10ps
`default_nettype none
module ahp_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rst_line_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] da,
  input wire logic diow_n,
  input wire logic dior_n,
  input wire logic dmack_n,
  input wire logic h_dd_oe,
  input wire logic d_dd_oe,
  input wire logic iordy,
  input wire logic [ahp_pkg::DW-1:0] dd
);
  // one cycle of slack for where the count starts
  localparam int RST_MIN = ahp_pkg::RESET_CYC - 1;
  int low_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      low_cnt <= 0;
    else if (!rst_line_n)
      low_cnt <= low_cnt + 1;
  end
  sequence s_stop_open;
    diow_n [*4] ##[1:3] !diow_n;
  endsequence
  sequence s_word_held;
    dd == $past(dd, 2) ##1 $stable(dd);
  endsequence
  AST_RST_HOLD: assert property ($rose(rst_line_n) |-> low_cnt >= RST_MIN)
    else $error("link reset too short");
  AST_BUS_ONE: assert property (!(h_dd_oe && d_dd_oe))
    else $error("both ends drive the bus");
  AST_STOP_OPEN: assert property ($fell(dmack_n) |-> s_stop_open)
    else $error("stop order wrong at burst start");
  AST_NO_EARLY: assert property (
    $fell(dmack_n) |-> (!d_dd_oe && $stable(iordy)) [*4])
    else $error("data moved before stop negated");
  AST_STOP_END: assert property (
    !dmack_n && $rose(diow_n) |-> ##[1:12] !d_dd_oe ##[0:12] dmack_n)
    else $error("burst not ended by stop");
  AST_PIO_SEL: assert property (
    dmack_n && (!diow_n || !dior_n) |-> (cs0_n ^ cs1_n) && $stable(da))
    else $error("bad select during strobe");
  AST_WR_PULSE: assert property (
    dmack_n && $fell(diow_n) |-> !diow_n [*8] ##[1:8] diow_n)
    else $error("write strobe width wrong");
  AST_HSTB_DATA: assert property (
    !dmack_n && h_dd_oe && !diow_n && $changed(dior_n) |-> s_word_held)
    else $error("host word not held at strobe");
  AST_DSTB_DATA: assert property (
    !dmack_n && d_dd_oe && !diow_n && $changed(iordy) |-> s_word_held)
    else $error("device word not held at strobe");
endmodule
`default_nettype wire

// ===== tb_ata_host_port_signals.sv
// Purpose: run host and device ends against each other
// Assumes: both ends share clk, reset_n and dma_in_mode
// Notes: received words gather in one queue for checking
`timescale 1ns/10ps
`default_nettype none
module tb_ata_host_port_signals;
  localparam logic [20:0] ROWS [6] = '{21'h17A5C3, 21'h1E0F0F, 21'h000000,
    21'h0F0000, 21'h10FFFF, 21'h0A0000};
  logic clk, reset_n, cmd_valid, cmd_ready, cmd_write, cmd_ctrl, rsp_valid;
  logic dma_in_mode, stop_req, in_pause, in_valid, out_valid, out_ready;
  logic intrq, pio_wr, pio_rd, pio_ctrl, intrq_req, dma_enable, tx_valid;
  logic tx_ready, rx_valid, rx_ready, burst_active, link_reset, wr_seen;
  logic [2:0] cmd_da, pio_da;
  logic [15:0] cmd_wdata, rsp_rdata, in_data, out_data, pio_wdata, tx_data;
  logic [15:0] rx_data, pio_rdata, wr_data, wr_tag;
  int mismatches, cmp_count, cyc, n, k, kmax;
  logic [15:0] got_q[$];
  ahp_if link();
  ahp_host i_ahp_host (.link(link.host), .*);
  ahp_device i_ahp_device (.link(link.dev), .*);
  ahp_monitor i_ahp_monitor (.clk(clk), .reset_n(reset_n),
    .rst_line_n(link.rst_line_n), .cs0_n(link.cs0_n), .cs1_n(link.cs1_n),
    .da(link.da), .diow_n(link.diow_n), .dior_n(link.dior_n),
    .dmack_n(link.dmack_n), .h_dd_oe(link.h_dd_oe),
    .d_dd_oe(link.d_dd_oe), .iordy(link.iordy), .dd(link.dd));
  assign pio_rdata = {12'hC30, pio_ctrl, pio_da};
  assign out_valid = k < kmax;
  assign out_data = 16'hB000 + 16'(k);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (out_ready && out_valid)
      k <= k + 1;
    if (in_valid)
      got_q.push_back(in_data);
    if (rx_valid && rx_ready)
      got_q.push_back(rx_data);
    if (pio_wr) begin
      wr_seen <= 1'b1;
      wr_data <= pio_wdata;
      wr_tag <= {12'h000, pio_ctrl, pio_da};
    end
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic pio(input logic [20:0] r);
    cmd_write = r[20];
    cmd_ctrl = r[19];
    cmd_da = r[18:16];
    cmd_wdata = r[15:0];
    cmd_valid = 1'b1;
    wr_seen = 1'b0;
    for (n = 0; n < 100 && cmd_ready !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 100 && rsp_valid !== 1'b1 && wr_seen !== 1'b1; n++)
      @(negedge clk);
    if (r[20]) begin
      check(wr_data, r[15:0]);
      check(wr_tag, {12'h000, r[19:16]});
    end else
      check(rsp_rdata, {12'hC30, r[19:16]});
  endtask
  task automatic drain_check(input logic [15:0] base, input int cnt);
    check(16'(got_q.size()), 16'(cnt));
    foreach (got_q[i]) check(got_q[i], base + 16'(i));
    got_q.delete();
  endtask
  initial begin
    reset_n = 1'b0;
    {cmd_valid, cmd_write, cmd_ctrl, stop_req, intrq_req, dma_enable} = '0;
    {tx_valid, rx_ready, cmd_da, cmd_wdata, tx_data} = '0;
    dma_in_mode = 1'b1;
    in_pause = 1'b1;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (20) @(negedge clk);
    check(16'(link_reset), 16'h0001);
    for (n = 20; n < 3000 && cmd_ready !== 1'b1; n++) @(negedge clk);
    check(16'(n >= ahp_pkg::RESET_CYC - 1), 16'h0001);
    check(16'(link.rst_line_n), 16'h0001);
    foreach (ROWS[i]) pio(ROWS[i]);
    // fill the tx buffer until it refuses, link idle meanwhile
    tx_valid = 1'b1;
    tx_data = 16'hA000;
    for (n = 0; n < 20 && tx_ready === 1'b1; n++) begin
      @(negedge clk);
      tx_data = 16'hA001 + 16'(n);
    end
    tx_valid = 1'b0;
    check(16'(n), 16'h0008);
    dma_enable = 1'b1;
    repeat (60) @(negedge clk);
    check(16'(got_q.size()), 16'h0000);
    in_pause = 1'b0;
    for (n = 0; n < 500 && burst_active !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 500 && burst_active !== 1'b0; n++) @(negedge clk);
    drain_check(16'hA000, 8);
    dma_in_mode = 1'b0;
    kmax = 12;
    repeat (300) @(negedge clk);
    check(16'(k < kmax), 16'h0001);
    rx_ready = 1'b1;
    for (n = 0; n < 800 && got_q.size() < 12; n++) @(negedge clk);
    stop_req = 1'b1;
    dma_enable = 1'b0;
    for (n = 0; n < 500 && burst_active !== 1'b0; n++) @(negedge clk);
    check(16'(burst_active), 16'h0000);
    stop_req = 1'b0;
    drain_check(16'hB000, 12);
    intrq_req = 1'b1;
    repeat (10) @(negedge clk);
    check(16'(intrq), 16'h0001);
    intrq_req = 1'b0;
    repeat (10) @(negedge clk);
    check(16'(intrq), 16'h0000);
    pio(ROWS[3]);
    print_verdict();
  end
endmodule
`default_nettype wire
